// ### spi_port_pkg.sv
// Shared constants and carrier types of the serial port control block
package spi_port_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned BITS_PER_TX = 8;
	localparam int unsigned FIFO_DEPTH  = 16;
	localparam int unsigned RATE_W      = 2;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0]  SHIFT_RESET  = 8'h00;
	localparam logic [3:0]  BITCNT_RESET = 4'h0;
	localparam logic [6:0]  DIV_RESET    = 7'h00;
	localparam logic        CTRL_MASTER_RESET = 1'b1;
	localparam logic        CTRL_PHASE_RESET  = 1'b1;

	// ----------------------------------------------------------------
	// Master clock divide: half serial clock period in bus cycles
	// ----------------------------------------------------------------
	localparam logic [6:0] HALF_DIV2   = 7'h01;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV32  = 7'h10;
	localparam logic [6:0] HALF_DIV128 = 7'h40;

	// Control and configuration bits, written by software
	typedef struct packed {
		logic              port_enable;
		logic              controller_select;
		logic              clock_polarity;
		logic              clock_phase;
		logic              open_drain_select;
		logic              tx_irq_enable;
		logic              rx_irq_enable;
		logic              err_irq_enable;
		logic              fault_detect_enable;
		logic              rate_select_hi;
		logic              rate_select_lo;
	} ctrl_s;

	// Status flags seen by software
	typedef struct packed {
		logic tx_empty_flag;
		logic rx_full_flag;
		logic overrun_flag;
		logic select_fault_flag;
	} status_s;

	// Pin pair: output and active-low output enable
	typedef struct packed {
		logic out;
		logic oe_n;
	} pin_drv_s;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_FINISH = 2'b10
	} xfer_state_e;

endpackage

// ### spi_tx_fifo.sv
// Parameterised valid/ready FIFO feeding the transmit data register
`timescale 1ns/10ps
`default_nettype none
module spi_tx_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             flush_i,
	// Filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ff];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage has no reset; only pointers matter
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || flush_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // spi_tx_fifo
`default_nettype wire

// ### spi_pin_sync.sv
// Three-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync #(
	parameter int unsigned N = 3
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Raw pins and filtered levels
	input  wire logic [N-1:0] pin_i,
	output logic      [N-1:0] level_o
);
	logic [N-1:0] s1_ff;
	logic [N-1:0] s2_ff;
	logic [N-1:0] s3_ff;

	// Level changes only once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_ff   <= '1;
			s2_ff   <= '1;
			s3_ff   <= '1;
			level_o <= '1;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < N; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					level_o[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule // spi_pin_sync
`default_nettype wire

// ### spi_port_ctrl.sv
// Serial peripheral port: flags, requests, partial reset, queue, pins
//
// Notes on behaviour
// - Transmit request only with tx empty, tx enable and port enable.
// - Receive request only with rx full, rx enable and port enable.
// - One error request from overrun or select fault, gated by err enable.
// - Select fault flag never sets while fault detection is off.
// - Rx full sets whenever a byte moves into the receive register.
// - Tx empty sets whenever a byte moves into the shift register.
// - Port disabled: tx empty set, transfer aborted, shifter cleared, pins released.
// - Config bits and rx, overrun, fault flags kept when port disabled; reset clears them, except it sets the master and phase config bits.
// - Master select fault with detection on clears the port enable.
// - Master starts a queued byte right after the previous one ends.
// - Slave with no new byte resends what the shifter last held.
// - Idle master, or idle slave with empty shifter, passes a written byte to the shifter within two cycles.
// - Busy slave loads the shifter only after the transfer ends.
// - Wait mode keeps running, blocks register access, requests still wake.
// - Break mode with flag-clear disabled ignores data writes.
// - Open-drain select makes the master data output open-drain.
// - Slave drives master-in pin only while selected; otherwise released.
// - While enabled the port owns data and clock pin direction.
// - A transfer is eight clock cycles, one byte each way.
// - Deselected slave ignores clock; select is port input when owned, except master with fault detection off.
// - Fault: master sees select low, or slave sees select rise at any time or stay high mid-transfer.
// - Status read seeing overrun, then data read, clears overrun.
// - Status read seeing fault, then control write, clears fault if gone.
// - Status read seeing rx full, then data read, clears rx full.
`timescale 1ns/10ps
`default_nettype none
module spi_port_ctrl
	import spi_port_pkg::*;
#(
	parameter int unsigned FIFO_WORDS = spi_port_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	// Software configuration (loaded on cfg_write_i)
	input  wire logic                      cfg_write_i,
	input  wire spi_port_pkg::ctrl_s       cfg_i,
	output spi_port_pkg::ctrl_s            cfg_o,
	// Software accesses
	input  wire logic                      status_read_i,
	input  wire logic                      data_read_i,
	input  wire logic                      wait_mode_i,
	input  wire logic                      break_mode_i,
	input  wire logic                      break_flag_clear_enable_i,
	// Transmit stream
	input  wire logic                      tx_valid_i,
	output logic                           tx_ready_o,
	input  wire logic [7:0]                tx_data_i,
	// Receive data and status
	output logic      [7:0]                rx_data_o,
	output spi_port_pkg::status_s          status_o,
	// Interrupt requests
	output logic                           tx_irq_o,
	output logic                           rx_irq_o,
	output logic                           err_irq_o,
	// Pins
	input  wire logic                      serial_clock_pin_i,
	output spi_port_pkg::pin_drv_s         serial_clock_pin_o,
	input  wire logic                      mosi_i,
	output spi_port_pkg::pin_drv_s         mosi_o,
	input  wire logic                      miso_i,
	output spi_port_pkg::pin_drv_s         miso_o,
	input  wire logic                      slave_select_n_i,
	output logic                           port_owns_pins_o,
	output logic                           select_is_spi_input_o
);
	import spi_port_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ctrl_s       ctrl_ff;
	status_s     stat_ff;
	xfer_state_e state_ff;
	logic [7:0]  shift_ff;
	logic [7:0]  txbuf_ff;
	logic        txbuf_full_ff;
	logic [7:0]  rxreg_ff;
	logic [3:0]  bitcnt_ff;
	logic [6:0]  div_ff;
	logic        sck_ff;
	logic        sck_prev_ff;
	logic        ss_prev_ff;
	logic        in_bit_ff;
	logic        ovr_armed_ff;
	logic        rxf_armed_ff;
	logic        select_fault_flag_armed_ff;
	logic        shift_full_ff;
	logic        shift_take;
	logic [2:0]  pin_lvl;
	logic        sck_lvl;
	logic        ss_n_lvl;
	logic        miso_lvl;
	logic        mosi_lvl;
	logic        en;
	logic        master;
	logic        fifo_valid;
	logic        fifo_pop;
	logic [7:0]  fifo_data;
	logic        accept_ok;
	logic        fault_now;
	logic        slave_sel;
	logic        sck_edge;
	logic        lead_edge;
	logic        trail_edge;
	logic        xfer_done;
	logic        master_tick;
	logic [6:0]  half_period;
	logic        rx_bit;

	assign en     = ctrl_ff.port_enable;
	assign master = ctrl_ff.controller_select;
	// Idle slave keeps its loaded byte, so a second write waits in the register
	assign shift_take = txbuf_full_ff && ((state_ff == ST_FINISH) ||
		(state_ff == ST_IDLE && (master || !shift_full_ff)));

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] half_of(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'b00:   half_of = HALF_DIV2;
			2'b01:   half_of = HALF_DIV8;
			2'b10:   half_of = HALF_DIV32;
			2'b11:   half_of = HALF_DIV128;
		endcase
	endfunction

	assign half_period = half_of(ctrl_ff.rate_select_hi, ctrl_ff.rate_select_lo);

	// ----------------------------------------------------------------
	// Pin synchronisers and the transmit queue
	// ----------------------------------------------------------------
	spi_pin_sync #(.N(3)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   ({serial_clock_pin_i, slave_select_n_i, miso_i}),
		.level_o (pin_lvl)
	);
	assign {sck_lvl, ss_n_lvl, miso_lvl} = pin_lvl;
	assign mosi_lvl = mosi_i;

	// Writes in wait mode or a masked break are not accepted
	assign accept_ok = !wait_mode_i &&
		!(break_mode_i && !break_flag_clear_enable_i);

	spi_tx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_WORDS)) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (1'b0),
		.in_valid_i  (tx_valid_i && accept_ok),
		.in_ready_o  (tx_ready_o),
		.in_data_i   (tx_data_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	// Queue feeds the data register only while it is empty
	assign fifo_pop = fifo_valid && !txbuf_full_ff && accept_ok;

	// ----------------------------------------------------------------
	// Transfer timing
	// ----------------------------------------------------------------
	assign slave_sel   = !master && !ss_n_lvl;
	// Deselected slave ignores every clock edge
	assign sck_edge    = (sck_lvl != sck_prev_ff) && slave_sel;
	assign master_tick = master && (div_ff == 7'h01);
	// Leading edge leaves the idle level
	assign lead_edge   = master ? (master_tick && (sck_ff == ctrl_ff.clock_polarity))
		: (sck_edge && (sck_lvl != ctrl_ff.clock_polarity));
	assign trail_edge  = master ? (master_tick && (sck_ff != ctrl_ff.clock_polarity))
		: (sck_edge && (sck_lvl == ctrl_ff.clock_polarity));
	assign rx_bit      = master ? miso_lvl : mosi_lvl;
	// Eighth trailing edge ends the byte
	assign xfer_done   = (state_ff == ST_ACTIVE) && trail_edge &&
		(bitcnt_ff == 4'(BITS_PER_TX - 1));

	// Faults per mode; none while detection is off
	assign fault_now = en && ctrl_ff.fault_detect_enable &&
		((master && !ss_n_lvl) ||
		 (!master && ss_n_lvl && !ss_prev_ff) ||
		 (!master && ss_n_lvl && (state_ff == ST_ACTIVE)));

	// Master clock divider, running only while master, enabled and in a transfer
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !en || !master || state_ff != ST_ACTIVE) begin
			div_ff <= DIV_RESET;
		end else if (div_ff == 7'h01 || div_ff == DIV_RESET) begin
			div_ff <= half_period;
		end else begin
			div_ff <= div_ff - 7'h01;
		end
	end

	// Edge history of the synchronised pins
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sck_prev_ff <= 1'b0;
			ss_prev_ff  <= 1'b1;
		end else begin
			sck_prev_ff <= sck_lvl;
			ss_prev_ff  <= ss_n_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Transfer state, shifter and bit counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !en) begin
			state_ff  <= ST_IDLE;
			shift_ff  <= SHIFT_RESET;
			bitcnt_ff <= BITCNT_RESET;
			sck_ff    <= ctrl_ff.clock_polarity;
			in_bit_ff <= 1'b0;
			shift_full_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					sck_ff <= ctrl_ff.clock_polarity;
					if (shift_take) begin
						// Idle master, or idle slave with empty shifter, loads shifter at once
						shift_ff      <= txbuf_ff;
						shift_full_ff <= 1'b1;
					end
					if (master && txbuf_full_ff) begin
						state_ff <= ST_ACTIVE;
					end else if (!master && slave_sel &&
						(!ctrl_ff.clock_phase ? ss_prev_ff : lead_edge)) begin
						state_ff <= ST_ACTIVE;
						if (lead_edge) begin
							in_bit_ff <= rx_bit;
						end
					end
				end
				ST_ACTIVE: begin
					if (master_tick) begin
						sck_ff <= !sck_ff;
					end
					if (lead_edge) begin
						in_bit_ff <= rx_bit;
					end
					if (trail_edge) begin
						// Old bits shift out; slave keeps last byte
						shift_ff  <= {shift_ff[6:0], in_bit_ff};
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end
					if (xfer_done) begin
						state_ff  <= ST_FINISH;
						bitcnt_ff <= BITCNT_RESET;
						shift_full_ff <= 1'b0;
					end
					if (!master && ss_n_lvl && ctrl_ff.fault_detect_enable) begin
						state_ff  <= ST_IDLE;
						bitcnt_ff <= BITCNT_RESET;
					end
				end
				ST_FINISH: begin
					// Busy slave loads only after completion
					if (shift_take) begin
						shift_ff      <= txbuf_ff;
						shift_full_ff <= 1'b1;
					end
					state_ff <= (master && txbuf_full_ff) ? ST_ACTIVE : ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Received byte lands in the receive register unless overrun
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rxreg_ff <= SHIFT_RESET;
		end else if (state_ff == ST_FINISH && !stat_ff.rx_full_flag &&
			!stat_ff.overrun_flag) begin
			rxreg_ff <= shift_ff;
		end
	end

	// ----------------------------------------------------------------
	// Transmit data register and empty flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			txbuf_full_ff <= 1'b0;
			txbuf_ff      <= SHIFT_RESET;
		end else if (!en) begin
			txbuf_full_ff <= 1'b0;
		end else if (shift_take) begin
			txbuf_full_ff <= 1'b0;
		end else if (fifo_pop) begin
			txbuf_ff      <= fifo_data;
			txbuf_full_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Software-visible flags; system reset clears config except master and phase bits, which it sets; master fault clears enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= '0;
			ctrl_ff.controller_select <= CTRL_MASTER_RESET;
			ctrl_ff.clock_phase       <= CTRL_PHASE_RESET;
		end else if (fault_now && master) begin
			ctrl_ff.port_enable <= 1'b0;
		end else if (cfg_write_i && !wait_mode_i) begin
			ctrl_ff <= cfg_i;
		end
	end

	// Arm on status reads that see a flag set
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rxf_armed_ff  <= 1'b0;
			ovr_armed_ff  <= 1'b0;
			select_fault_flag_armed_ff <= 1'b0;
		end else if (status_read_i && !wait_mode_i) begin
			rxf_armed_ff  <= stat_ff.rx_full_flag;
			ovr_armed_ff  <= stat_ff.overrun_flag;
			select_fault_flag_armed_ff <= stat_ff.select_fault_flag;
		end else if (fault_now) begin
			select_fault_flag_armed_ff <= 1'b0;
		end
	end

	// Setting wins over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stat_ff <= '0;
			stat_ff.tx_empty_flag <= 1'b1;
		end else begin
			stat_ff.tx_empty_flag <= !txbuf_full_ff || !en;
			if (state_ff == ST_FINISH && !stat_ff.rx_full_flag &&
				!stat_ff.overrun_flag) begin
				stat_ff.rx_full_flag <= 1'b1;
			end else if (data_read_i && !wait_mode_i && rxf_armed_ff) begin
				stat_ff.rx_full_flag <= 1'b0;
			end
			if (state_ff == ST_FINISH && stat_ff.rx_full_flag) begin
				stat_ff.overrun_flag <= 1'b1;
			end else if (data_read_i && !wait_mode_i && ovr_armed_ff) begin
				stat_ff.overrun_flag <= 1'b0;
			end
			if (fault_now) begin
				stat_ff.select_fault_flag <= 1'b1;
			end else if (cfg_write_i && !wait_mode_i && select_fault_flag_armed_ff) begin
				stat_ff.select_fault_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Requests, outputs and pin ownership
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tx_irq_o  <= 1'b0;
			rx_irq_o  <= 1'b0;
			err_irq_o <= 1'b0;
		end else begin
			// Level requests, also active in wait mode to wake the core
			tx_irq_o  <= stat_ff.tx_empty_flag && ctrl_ff.tx_irq_enable &&
				en;
			rx_irq_o  <= stat_ff.rx_full_flag && ctrl_ff.rx_irq_enable &&
				en;
			err_irq_o <= ctrl_ff.err_irq_enable && (stat_ff.overrun_flag ||
				stat_ff.select_fault_flag);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cfg_o                 <= '0;
			status_o              <= '0;
			rx_data_o             <= SHIFT_RESET;
			port_owns_pins_o      <= 1'b0;
			select_is_spi_input_o <= 1'b0;
			serial_clock_pin_o    <= '{out: 1'b0, oe_n: 1'b1};
			mosi_o                <= '{out: 1'b0, oe_n: 1'b1};
			miso_o                <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			cfg_o     <= ctrl_ff;
			status_o  <= stat_ff;
			rx_data_o <= rxreg_ff;
			port_owns_pins_o      <= en;
			select_is_spi_input_o <= en &&
				(!master || ctrl_ff.fault_detect_enable);
			// Master drives clock; slave leaves it as input
			serial_clock_pin_o.out  <= sck_ff;
			serial_clock_pin_o.oe_n <= !(en && master);
			mosi_o.out  <= shift_ff[7];
			// Open drain drives only zeros
			mosi_o.oe_n <= !(en && master &&
				(!ctrl_ff.open_drain_select || !shift_ff[7]));
			miso_o.out  <= shift_ff[7];
			miso_o.oe_n <= !(en && slave_sel &&
				(!ctrl_ff.open_drain_select || !shift_ff[7]));
		end
	end
endmodule // spi_port_ctrl
`default_nettype wire

// ### spi_port_ctrl_asserts.sv
// Port-level checker for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module spi_port_ctrl_asserts
	import spi_port_pkg::*;
(
	// Clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_n_i,
	// Watched ports
	input wire logic                  cfg_write_i,
	input wire logic                  slave_select_n_i,
	input wire spi_port_pkg::ctrl_s   cfg_o,
	input wire spi_port_pkg::status_s status_o,
	input wire logic                  tx_irq_o,
	input wire logic                  rx_irq_o,
	input wire logic                  err_irq_o,
	input wire spi_port_pkg::pin_drv_s serial_clock_pin_o,
	input wire spi_port_pkg::pin_drv_s mosi_o,
	input wire spi_port_pkg::pin_drv_s miso_o,
	input wire logic                  select_is_spi_input_o
);
	logic tx_t, rx_t, er_t, off;
	// Request terms; requests follow their terms in the same cycle
	assign tx_t = status_o.tx_empty_flag & cfg_o.tx_irq_enable
		& cfg_o.port_enable;
	assign rx_t = status_o.rx_full_flag & cfg_o.rx_irq_enable
		& cfg_o.port_enable;
	assign er_t = cfg_o.err_irq_enable
		& (status_o.overrun_flag | status_o.select_fault_flag);
	assign off = !cfg_o.port_enable;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_tx_irq_level: assert property ((tx_t[*2] |-> tx_irq_o) and (!tx_t[*2] |-> !tx_irq_o))
		else $error("tx request off its term");
	a_rx_irq_level: assert property ((rx_t[*2] |-> rx_irq_o) and (!rx_t[*2] |-> !rx_irq_o))
		else $error("rx request off its term");
	a_err_irq_level: assert property ((er_t[*2] |-> err_irq_o) and (!er_t[*2] |-> !err_irq_o))
		else $error("error request off its term");
	a_fault_gated: assert property (!cfg_o.fault_detect_enable[*2] |-> !$rose(status_o.select_fault_flag))
		else $error("fault flag set with detection off");
	a_off_tx_empty: assert property (off[*3] |-> status_o.tx_empty_flag)
		else $error("tx empty low while disabled");
	a_off_pins_free: assert property (off[*3] |-> serial_clock_pin_o.oe_n && mosi_o.oe_n && miso_o.oe_n && !select_is_spi_input_o)
		else $error("pins held while disabled");
	a_miso_deselect: assert property (slave_select_n_i[*6] |-> miso_o.oe_n)
		else $error("miso driven while deselected");
	a_open_drain_out: assert property (cfg_o.open_drain_select[*2] |-> mosi_o.oe_n || !mosi_o.out)
		else $error("mosi driven high in open drain");
	a_cfg_held: assert property (!cfg_write_i[*3] |=> $stable(cfg_o[9:0]))
		else $error("config changed without write");
	a_fault_disables: assert property ($rose(status_o.select_fault_flag) && cfg_o.controller_select |-> ##[0:3] off)
		else $error("master fault left port enabled");
	// Main scenarios reached
	c_tx_irq: cover property (tx_irq_o && rx_irq_o);
	c_overrun: cover property ($rose(status_o.overrun_flag));
	c_fault: cover property ($rose(status_o.select_fault_flag));
endmodule // spi_port_ctrl_asserts
bind spi_port_ctrl spi_port_ctrl_asserts chk (.clk_i, .rst_n_i,
	.cfg_write_i, .slave_select_n_i, .cfg_o, .status_o, .tx_irq_o,
	.rx_irq_o, .err_irq_o, .serial_clock_pin_o, .mosi_o, .miso_o,
	.select_is_spi_input_o);
`default_nettype wire

// ### spi_peer_model.sv
// Remote controller on the serial link, phase one, polarity zero
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
	// Link pins
	output logic      sck_o,
	output logic      sel_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// Idle link: clock still low, select high
	initial begin
		sck_o = 1'b0;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// One byte: leading edge launches, trailing edge samples
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		sel_n_o = 1'b0;
		#250;
		for (int i = 7; i >= 0; i--) begin
			sck_o = 1'b1;
			mosi_o = tx[i];
			#62.5;
			sck_o = 1'b0;
			rx[i] = miso_i;
			#62.5;
		end
		#250;
		sel_n_o = 1'b1;
		mosi_o = ~tx[0]; // Released line must not keep the last bit
	endtask
	// A second controller grabbing the select line
	task automatic grab_select;
		sel_n_o = 1'b0;
		#200;
		sel_n_o = 1'b1;
	endtask
endmodule // spi_peer_model
`default_nettype wire

// ### spi_port_ctrl_tb.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import spi_port_pkg::*;
	logic clk_i, rst_n_i, cfg_write_i, status_read_i, data_read_i;
	logic wait_mode_i, break_mode_i, tx_valid_i, tx_ready_o, owns, ssin;
	logic tx_irq_o, rx_irq_o, err_irq_o;
	logic [7:0] tx_data_i, rx_data_o, got;
	logic [15:0] cap;
	ctrl_s cfg_i, cfg_o;
	status_s status_o;
	pin_drv_s sck_o, mosi_o, miso_o;
	wire peer_sck, peer_sel_n, peer_mosi;
	// Pin levels from all drivers; open drain data has a pull-up
	wire sck_w = sck_o.oe_n ? peer_sck : sck_o.out;
	wire mosi_w = !mosi_o.oe_n ? mosi_o.out
		: (cfg_o.open_drain_select ? 1'b1 : peer_mosi);
	wire miso_w = miso_o.oe_n ? mosi_w : miso_o.out;
	int error_cnt, comparisons, edges, n;
	spi_port_ctrl DUT (.clk_i, .rst_n_i, .cfg_write_i, .cfg_i, .cfg_o,
		.status_read_i, .data_read_i, .wait_mode_i, .break_mode_i,
		.break_flag_clear_enable_i(1'b0), .tx_valid_i, .tx_ready_o,
		.tx_data_i, .rx_data_o, .status_o, .tx_irq_o, .rx_irq_o,
		.err_irq_o, .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
		.mosi_i(mosi_w), .mosi_o, .miso_i(miso_w), .miso_o,
		.slave_select_n_i(peer_sel_n), .port_owns_pins_o(owns),
		.select_is_spi_input_o(ssin));
	spi_peer_model peer (.sck_o(peer_sck), .sel_n_o(peer_sel_n),
		.mosi_o(peer_mosi), .miso_i(miso_w));
	always #5 clk_i = ~clk_i;
	// Count master clock pulses, sample data mid-high
	always @(posedge sck_w) begin
		if (!sck_o.oe_n) begin
			#300;
			cap = {cap[14:0], mosi_w};
			edges++;
		end
	end
	task automatic summarize;
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] e, a);
		comparisons++;
		if (a !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, e, a);
		end
	endtask
	task automatic waitc(input int c);
		repeat (c) @(negedge clk_i);
	endtask
	task automatic cfgw(input logic [10:0] c);
		@(negedge clk_i);
		cfg_i = ctrl_s'(c);
		cfg_write_i = 1'b1;
		@(negedge clk_i);
		cfg_write_i = 1'b0;
	endtask
	// Offer a word only while the queue can take it
	task automatic push(input logic [7:0] d);
		@(negedge clk_i);
		tx_data_i = d;
		tx_valid_i = tx_ready_o;
		@(negedge clk_i);
		tx_valid_i = 1'b0;
	endtask
	task automatic rd(input logic s, d);
		@(negedge clk_i);
		status_read_i = s;
		data_read_i = d;
		@(negedge clk_i);
		status_read_i = 1'b0;
		data_read_i = 1'b0;
	endtask
	task automatic t_reset;
		waitc(3);
		check("status", 16'h0008, {12'h000, status_o});
		check("cfg", 16'h0280, {5'h00, cfg_o});
	endtask
	// Master, open drain, slowest rate, data looped back
	task automatic t_master;
		cfgw(11'h6FB);
		break_mode_i = 1'b1;
		push(8'h55);
		waitc(300);
		break_mode_i = 1'b0;
		check("brk", 16'h0, 16'(edges));
		push(8'hA5);
		waitc(6);
		check("tx1", 16'h1, {15'h0, status_o.tx_empty_flag});
		push(8'h3C);
		waitc(6);
		check("tx2", 16'h0, {15'h0, status_o.tx_empty_flag});
		for (int i = 0; i < 2400 && edges < 16; i++) @(negedge clk_i);
		waitc(100);
		check("wire", 16'hA53C, cap);
		check("rxd", 16'h00A5, {8'h00, rx_data_o});
		check("st", 16'h000E, {12'h000, status_o});
		check("irq", 16'h0007, {13'h0, tx_irq_o, rx_irq_o, err_irq_o});
		wait_mode_i = 1'b1;
		cfgw(11'h2FB);
		waitc(3);
		check("wcfg", 16'h06FB, {5'h00, cfg_o});
		check("wirq", 16'h0001, {15'h0, rx_irq_o});
		wait_mode_i = 1'b0;
		cfgw(11'h2FB);
		waitc(3);
		check("off", 16'h001C, {11'h000, status_o, owns});
		rd(1'b1, 1'b0);
		rd(1'b0, 1'b1);
		waitc(3);
		check("clr", 16'h08A5, {4'h0, status_o, rx_data_o});
		cfgw(11'h6FB);
		push(8'hFF);
		waitc(300);
		cfgw(11'h2FB);
		waitc(40);
		n = edges;
		waitc(300);
		check("abort", 16'(n), 16'(edges));
	endtask
	task automatic t_fault;
		cfgw(11'h688);
		peer.grab_select();
		waitc(10);
		check("nofd", 16'h0030, {10'h0, cfg_o.port_enable, status_o, ssin});
		cfgw(11'h68C);
		peer.grab_select();
		waitc(10);
		check("fault", 16'h0009, {11'h0, cfg_o.port_enable, status_o});
		check("eirq", 16'h0001, {15'h0, err_irq_o});
		rd(1'b1, 1'b0);
		cfgw(11'h490);
		waitc(4);
		check("fclr", 16'h0000, {15'h0, status_o.select_fault_flag});
	endtask
	// Slave: fill the queue, then drain it with a stalling controller
	task automatic t_slave;
		n = 0;
		waitc(4);
		while (tx_ready_o && n < 30) begin
			push(8'h10 + 8'(n));
			n++;
		end
		check("fill", 16'(FIFO_DEPTH + 2), 16'(n));
		check("ssin", 16'h0001, {15'h0, ssin});
		for (int i = 0; i <= n; i++) begin
			peer.xfer(8'hC3, got);
			#700;
			check("miso", (i < n) ? 16'h10 + 16'(i) : 16'h00C3, {8'h00, got});
		end
		check("srx", 16'h00C3, {8'h00, rx_data_o});
	endtask
	initial begin
		{clk_i, rst_n_i, cfg_write_i, status_read_i, data_read_i} = '0;
		{wait_mode_i, break_mode_i, tx_valid_i, tx_data_i} = '0;
		{cfg_i, error_cnt, comparisons, edges, cap} = '0;
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_reset();
		t_master();
		t_fault();
		t_slave();
		summarize();
	end
	// Watchdog well past the expected run
	initial begin
		#600000;
		error_cnt++;
		summarize();
	end
endmodule // testbench
`default_nettype wire
